// ### jlp_pkg.sv
// constants and types shared by the low-power, loopback and receive filter block
package jlp_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    // quiet time that marks an idle bus
    localparam int IDLE_TIME_US  = 300;
    localparam int IDLE_CYC      = (IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // oscillator settling after a full stop
    localparam int OSC_SETTLE_US = 100;
    localparam int OSC_SETTLE_CYC =
        (OSC_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] LINK_CONTROL_ONE_ADDR = 8'h00;
    localparam logic [7:0] LINK_CONTROL_TWO_ADDR = 8'h04;
    localparam logic [7:0] STATE_VECTOR_ADDR     = 8'h08;
    localparam logic [7:0] STATUS_ADDR           = 8'h0c;

    // field positions
    localparam int WCM_BIT   = 0;
    localparam int ANALOG_LOOP_BIT_BIT = 0;
    localparam int DIGITAL_LOOP_BIT_BIT = 1;

    // values
    localparam logic [7:0] WAKE_VECTOR  = 8'h20;
    localparam logic [7:0] VECTOR_NONE  = 8'h00;
    localparam logic [3:0] FILT_MAX     = 4'hf;
    localparam logic [3:0] FILT_MIN     = 4'h0;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam logic [11:0] CNT_ZERO    = 12'h000;

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PM_RUN,
        PM_WAIT,
        PM_STOP_CPU_WAIT,
        PM_STOP_CPU_STOP,
        PM_SETTLE
    } jlp_pm_t;

endpackage

// ### jlp_top.sv
// power-saving, loopback and receive filter logic of the serial link controller
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module jlp_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cpu_wait_exec,
    input  wire logic        cpu_stop_exec,
    input  wire logic        tx_bit_in,
    input  wire logic        rx_digital_in,
    output logic             tx_digital_out,
    output logic             rx_filtered,
    output logic             core_clk_run,
    output logic             link_enable,
    output logic             wake_irq,
    output logic             wake_nmi
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                aw_got;
        logic [7:0]          aw_addr;
        logic                w_got;
        logic [31:0]         w_data;
        logic                w_lane0;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
        logic                wake_clock_mode_sel;
        logic                analog_loop_bit;
        logic                digital_loop_bit;
        jlp_pkg::jlp_pm_t    pm;
        logic [11:0]         settle_cnt;
        logic                vec_pend;
        logic                s1;
        logic                s2;
        logic                s3;
        logic                rx_stable;
        logic                smp;
        logic [3:0]          cnt;
        logic                filt;
        logic                idle_wait;
        logic [11:0]         idle_cnt;
        logic                tx_out;
        logic                tx_pin;
        logic                clk_run;
        logic                link_en;
        logic                irq;
        logic                nmi;
    } jlp_state_t;

    jlp_state_t st_ff;
    jlp_state_t nxt_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == jlp_pkg::LINK_CONTROL_ONE_ADDR) ||
                     (a == jlp_pkg::LINK_CONTROL_TWO_ADDR) ||
                     (a == jlp_pkg::STATE_VECTOR_ADDR) ||
                     (a == jlp_pkg::STATUS_ADDR);
    endfunction

    function automatic logic [11:0] cnt_step(input logic [11:0] c);
        cnt_step = c + 12'h001;
    endfunction

    logic in_low;
    logic clocks_on;
    logic loop_any;
    logic rise;
    logic filt_src;
    logic [7:0] vec_now;
    logic vec_read;

    always_comb begin
        nxt_st   = st_ff;
        in_low   = (st_ff.pm != jlp_pkg::PM_RUN);
        loop_any = st_ff.analog_loop_bit || st_ff.digital_loop_bit;
        vec_now  = st_ff.vec_pend ? jlp_pkg::WAKE_VECTOR : jlp_pkg::VECTOR_NONE;
        vec_read = 1'b0;

        // --------------------------------------------------------
        // pin input synchroniser, change taken when s2 and s3 agree
        // --------------------------------------------------------
        nxt_st.s1 = rx_digital_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.rx_stable = st_ff.s3;
        end
        rise = (st_ff.s2 == st_ff.s3) && st_ff.s3 && !st_ff.rx_stable;

        // --------------------------------------------------------
        // axi write channel
        // --------------------------------------------------------
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got   = 1'b1;
            nxt_st.w_data  = s_axi_wdata;
            nxt_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = addr_known(st_ff.aw_addr) ? jlp_pkg::RESP_OKAY
                                                      : jlp_pkg::RESP_SLVERR;
            if (st_ff.w_lane0) begin
                if (st_ff.aw_addr == jlp_pkg::LINK_CONTROL_ONE_ADDR) begin
                    nxt_st.wake_clock_mode_sel = st_ff.w_data[jlp_pkg::WCM_BIT];
                end else if (st_ff.aw_addr == jlp_pkg::LINK_CONTROL_TWO_ADDR) begin
                    nxt_st.analog_loop_bit = st_ff.w_data[jlp_pkg::ANALOG_LOOP_BIT_BIT];
                    nxt_st.digital_loop_bit = st_ff.w_data[jlp_pkg::DIGITAL_LOOP_BIT_BIT];
                end
            end
        end
        nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

        // --------------------------------------------------------
        // axi read channel
        // --------------------------------------------------------
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = jlp_pkg::RESP_OKAY;
            nxt_st.rdata  = 32'h0000_0000;
            if (s_axi_araddr == jlp_pkg::LINK_CONTROL_ONE_ADDR) begin
                nxt_st.rdata[jlp_pkg::WCM_BIT] = st_ff.wake_clock_mode_sel;
            end else if (s_axi_araddr == jlp_pkg::LINK_CONTROL_TWO_ADDR) begin
                nxt_st.rdata[jlp_pkg::ANALOG_LOOP_BIT_BIT] = st_ff.analog_loop_bit;
                nxt_st.rdata[jlp_pkg::DIGITAL_LOOP_BIT_BIT] = st_ff.digital_loop_bit;
            end else if (s_axi_araddr == jlp_pkg::STATE_VECTOR_ADDR) begin
                nxt_st.rdata[7:0] = vec_now;
                vec_read = 1'b1;
            end else if (s_axi_araddr == jlp_pkg::STATUS_ADDR) begin
                nxt_st.rdata[2:0]  = st_ff.pm;
                nxt_st.rdata[3]    = st_ff.filt;
                nxt_st.rdata[7:4]  = st_ff.cnt;
                nxt_st.rdata[8]    = st_ff.idle_wait;
                nxt_st.rdata[9]    = st_ff.clk_run;
            end else begin
                nxt_st.rresp = jlp_pkg::RESP_SLVERR;
            end
        end
        nxt_st.arready = !nxt_st.rvalid;

        // --------------------------------------------------------
        // power modes; link control registers are never touched by a wakeup, a stop wake sets the state vector
        // --------------------------------------------------------
        nxt_st.irq = 1'b0;
        nxt_st.nmi = 1'b0;
        if (vec_read) begin
            nxt_st.vec_pend = 1'b0;
        end
        case (st_ff.pm)
            jlp_pkg::PM_RUN: begin
                if (cpu_wait_exec) begin
                    nxt_st.pm = st_ff.wake_clock_mode_sel ? jlp_pkg::PM_STOP_CPU_WAIT
                                          : jlp_pkg::PM_WAIT;
                end else if (cpu_stop_exec) begin
                    nxt_st.pm = st_ff.wake_clock_mode_sel ? jlp_pkg::PM_STOP_CPU_STOP
                                          : jlp_pkg::PM_WAIT;
                end
            end
            jlp_pkg::PM_WAIT: begin
                if (rise && !loop_any) begin
                    nxt_st.pm  = jlp_pkg::PM_RUN;
                    nxt_st.irq = 1'b1;
                end
            end
            jlp_pkg::PM_STOP_CPU_WAIT: begin
                if (rise && !loop_any) begin
                    nxt_st.pm       = jlp_pkg::PM_RUN;
                    nxt_st.nmi      = 1'b1;
                    nxt_st.vec_pend = 1'b1;
                end
            end
            jlp_pkg::PM_STOP_CPU_STOP: begin
                if (rise && !loop_any) begin
                    nxt_st.pm         = jlp_pkg::PM_SETTLE;
                    nxt_st.settle_cnt = jlp_pkg::CNT_ZERO;
                    nxt_st.nmi        = 1'b1;
                    nxt_st.vec_pend   = 1'b1;
                end
            end
            jlp_pkg::PM_SETTLE: begin
                // clocks withheld while the oscillator settles
                nxt_st.settle_cnt = cnt_step(st_ff.settle_cnt);
                if (st_ff.settle_cnt == 12'(jlp_pkg::OSC_SETTLE_CYC - 1)) begin
                    nxt_st.pm = jlp_pkg::PM_RUN;
                end
            end
            default: begin
                nxt_st.pm = jlp_pkg::PM_RUN;
            end
        endcase

        // internal clocks run in run and wait only
        clocks_on = (st_ff.pm == jlp_pkg::PM_RUN) || (st_ff.pm == jlp_pkg::PM_WAIT);
        nxt_st.clk_run = (nxt_st.pm == jlp_pkg::PM_RUN) || (nxt_st.pm == jlp_pkg::PM_WAIT);

        // --------------------------------------------------------
        // receive filter, frozen while internal clocks are off
        // --------------------------------------------------------
        filt_src = st_ff.digital_loop_bit ? st_ff.tx_out : st_ff.rx_stable;
        if (clocks_on) begin
            nxt_st.smp = filt_src;
            if (st_ff.smp) begin
                if (st_ff.cnt != jlp_pkg::FILT_MAX) begin
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end
            end else begin
                if (st_ff.cnt != jlp_pkg::FILT_MIN) begin
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end
            end
            if (nxt_st.cnt == jlp_pkg::FILT_MAX) begin
                nxt_st.filt = 1'b1;
            end else if (nxt_st.cnt == jlp_pkg::FILT_MIN) begin
                nxt_st.filt = 1'b0;
            end
        end

        // --------------------------------------------------------
        // analog loop exit: hold off until the bus has been idle
        // --------------------------------------------------------
        if (st_ff.analog_loop_bit) begin
            nxt_st.idle_wait = 1'b1;
            nxt_st.idle_cnt  = jlp_pkg::CNT_ZERO;
        end else if (st_ff.idle_wait) begin
            if (st_ff.filt) begin
                nxt_st.idle_cnt = jlp_pkg::CNT_ZERO;
            end else if (st_ff.idle_cnt == 12'(jlp_pkg::IDLE_CYC - 1)) begin
                nxt_st.idle_wait = 1'b0;
            end else begin
                nxt_st.idle_cnt = cnt_step(st_ff.idle_cnt);
            end
        end
        nxt_st.link_en = !nxt_st.idle_wait && !nxt_st.digital_loop_bit;

        // --------------------------------------------------------
        // transmit path; no drive in low power or in digital loop
        // --------------------------------------------------------
        nxt_st.tx_out = tx_bit_in && !nxt_st.idle_wait && (nxt_st.pm == jlp_pkg::PM_RUN);
        nxt_st.tx_pin = nxt_st.tx_out && !nxt_st.digital_loop_bit;

        // --------------------------------------------------------
        // set wins over the read clear
        // --------------------------------------------------------
        if (st_ff.pm != jlp_pkg::PM_RUN && nxt_st.nmi) begin
            nxt_st.vec_pend = 1'b1;
        end
        if (in_low && !clocks_on) begin
            nxt_st.smp = st_ff.smp;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff         <= '0;
            st_ff.awready <= 1'b1;
            st_ff.wready  <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.pm      <= jlp_pkg::PM_RUN;
            st_ff.clk_run <= 1'b1;
            st_ff.link_en <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready  = st_ff.awready;
    assign s_axi_wready   = st_ff.wready;
    assign s_axi_bvalid   = st_ff.bvalid;
    assign s_axi_bresp    = st_ff.bresp;
    assign s_axi_arready  = st_ff.arready;
    assign s_axi_rvalid   = st_ff.rvalid;
    assign s_axi_rresp    = st_ff.rresp;
    assign s_axi_rdata    = st_ff.rdata;
    assign tx_digital_out = st_ff.tx_pin;
    assign rx_filtered    = st_ff.filt;
    assign core_clk_run   = st_ff.clk_run;
    assign link_enable    = st_ff.link_en;
    assign wake_irq       = st_ff.irq;
    assign wake_nmi       = st_ff.nmi;

endmodule

`default_nettype wire

// ### jlp_sva.sv
// assertion checker for the low-power, loopback and receive filter block
`timescale 1ns/100ps
`default_nettype none
module jlp_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_digital_in,
    input wire logic tx_digital_out,
    input wire logic rx_filtered,
    input wire logic core_clk_run,
    input wire logic link_enable,
    input wire logic wake_irq,
    input wire logic wake_nmi
);
    // ------------------------------------------------------------
    // run lengths of the raw pin while internal clocks run and the link is enabled
    // ------------------------------------------------------------
    logic [11:0] hi_ff;
    logic [11:0] lo_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || !core_clk_run || !link_enable) begin
            hi_ff <= 12'h000;
            lo_ff <= 12'h000;
        end else begin
            hi_ff <= rx_digital_in ? hi_ff + 12'h001 : 12'h000;
            lo_ff <= rx_digital_in ? 12'h000 : lo_ff + 12'h001;
        end
    end
    // cycles since a stop wake while internal clocks are still held
    logic [11:0] settle_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || core_clk_run) begin
            settle_ff <= 12'h000;
        end else if (wake_nmi || settle_ff != 12'h000) begin
            settle_ff <= settle_ff + 12'h001;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence nmi_pulse_s;
        wake_nmi ##1 !wake_nmi;
    endsequence
    nmi_single_a: assert property ($rose(wake_nmi) |-> nmi_pulse_s)
        else $error("stop wake pulse longer than one cycle");
    nmi_from_stop_a: assert property (wake_nmi |-> !$past(core_clk_run))
        else $error("stop wake without stopped clocks");
    clock_restart_a: assert property (settle_ff <= 12'(jlp_pkg::OSC_SETTLE_CYC))
        else $error("clocks not restarted after stop wake");
    irq_single_a: assert property (wake_irq |=> !wake_irq)
        else $error("wait wake pulse longer than one cycle");
    irq_clocks_a: assert property (wake_irq |-> $past(core_clk_run) && core_clk_run)
        else $error("wait wake while clocks stopped");
    wake_cause_a: assert property (wake_irq || wake_nmi |-> $past(rx_digital_in))
        else $error("wake without bus activity");
    loop_no_wake_a: assert property (!link_enable |-> !wake_irq && !wake_nmi)
        else $error("wake while detached");
    tx_quiet_a: assert property (!link_enable || !core_clk_run |-> !tx_digital_out)
        else $error("bus driven while detached or stopped");
    filt_rise_a: assert property ($rose(rx_filtered) && link_enable |-> hi_ff >= 12'd15)
        else $error("filtered rise too early");
    filt_fall_a: assert property ($fell(rx_filtered) && link_enable |-> lo_ff >= 12'd15)
        else $error("filtered fall too early");
    filt_high_a: assert property (hi_ff == 12'd24 |-> rx_filtered)
        else $error("filtered output not set");
    filt_low_a: assert property (lo_ff == 12'd24 |-> !rx_filtered)
        else $error("filtered output not cleared");
endmodule
bind jlp_top jlp_sva i_sva (.aclk, .aresetn, .rx_digital_in, .tx_digital_out, .rx_filtered,
    .core_clk_run, .link_enable, .wake_irq, .wake_nmi);
`default_nettype wire

// ### jlp_xcvr.sv
// behavioural model of the off-chip bus transceiver
`timescale 1ns/100ps
`default_nettype none
module jlp_xcvr (
    input wire logic       aclk,
    input wire logic       tx_digital_out,
    input wire logic       loop_mode,
    input wire logic       node_drive,
    input wire logic [1:0] lag,
    output logic           rx_digital_in
);
    // passive bus is pulled low; our driver makes it active, and so do other nodes outside loop mode
    logic [3:0] pipe_ff = 4'h0;
    logic       bus_level;
    assign bus_level = loop_mode ? tx_digital_out : (node_drive | tx_digital_out);
    always @(posedge aclk) pipe_ff <= {pipe_ff[2:0], bus_level};
    assign rx_digital_in = pipe_ff[lag];
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the low-power, loopback and receive filter block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        cpu_wait_exec = 1'h0, cpu_stop_exec = 1'h0, tx_bit_in = 1'h0;
    logic        node_drv = 1'h0, xcvr_loop = 1'h0, sel = 1'h0, stp, seen;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb = 4'hf, s;
    logic [2:0]  pm;
    logic [1:0]  lag = 2'h0, s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        rx_digital_in, tx_digital_out, rx_filtered, core_clk_run, link_enable;
    logic        wake_irq, wake_nmi;
    int          mismatches = 0, n_compared = 0, t;
    jlp_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpu_wait_exec, .cpu_stop_exec, .tx_bit_in, .rx_digital_in,
        .tx_digital_out, .rx_filtered, .core_clk_run, .link_enable, .wake_irq, .wake_nmi);
    jlp_xcvr i_xcvr (.aclk, .tx_digital_out, .loop_mode(xcvr_loop), .node_drive(node_drv), .lag,
        .rx_digital_in);
    initial forever #50 aclk = ~aclk;
    // ------------------------------------------------------------
    // expectations, comparisons and bus cycles
    // ------------------------------------------------------------
    function automatic logic [2:0] pm_expect(input logic stop_instr, input logic sel_bit);
        return sel_bit ? (stop_instr ? 3'h3 : 3'h2) : 3'h1;
    endfunction
    function automatic logic [31:0] status_word(input logic [2:0] p, input logic run,
                                                input logic [3:0] cnt, input logic rxf);
        return {22'h0, run, 1'h0, cnt, rxf, p};
    endfunction
    function automatic logic probe(input int k);
        case (k)
            0: return rx_filtered;
            1: return !rx_filtered;
            2: return wake_irq || wake_nmi;
            3: return core_clk_run;
            default: return link_enable;
        endcase
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_in(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("CHECK FAILED at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic count_until(input int k, input int lim);
        t = 0;
        do begin
            @(posedge aclk);
            t++;
        end while (probe(k) !== 1'h1 && t < lim);
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        check({s_axi_bvalid, s_axi_bresp}, {1'h1, (a > 8'h0c) ? 2'h2 : 2'h0});
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] ed);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        check({s_axi_rvalid, s_axi_rresp}, {1'h1, (a > 8'h0c) ? 2'h2 : 2'h0});
        check(s_axi_rdata, ed);
    endtask
    task automatic pulse_cpu(input logic st);
        @(posedge aclk);
        cpu_wait_exec <= !st;
        cpu_stop_exec <= st;
        @(posedge aclk);
        cpu_wait_exec <= 1'h0;
        cpu_stop_exec <= 1'h0;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h648f2636));
        repeat (16) @(posedge aclk);
        check({rx_filtered, core_clk_run, link_enable, wake_irq, wake_nmi}, 5'h0c);
        aresetn <= 1'h1;
        expect_reg(8'h0c, status_word(3'h0, 1'h1, 4'h0, 1'h0));
        for (int i = 0; i < 8; i++) begin
            v = $urandom();
            s = 4'($urandom());
            if (s[0]) sel = v[0];
            axi_write(8'h00, v, s);
            expect_reg(8'h00, {31'h0, sel});
        end
        axi_write(8'h10, 32'hffffffff, 4'hf);
        expect_reg(8'h10, 32'h0);
        for (int i = 0; i < 6; i++) begin
            lag <= 2'($urandom_range(0, 3));
            @(posedge aclk);
            node_drv <= 1'h1;
            repeat ($urandom_range(2, 11)) @(posedge aclk);
            node_drv <= 1'h0;
            repeat (40) @(posedge aclk);
            check(rx_filtered, 1'h0);
        end
        node_drv <= 1'h1;
        count_until(0, 60);
        check_in(t, 19 + lag, 22 + lag);
        repeat (20) @(posedge aclk);
        expect_reg(8'h0c, status_word(3'h0, 1'h1, 4'hf, 1'h1));
        node_drv <= 1'h0;
        repeat (8) @(posedge aclk);
        node_drv <= 1'h1;
        repeat (30) @(posedge aclk);
        check(rx_filtered, 1'h1);
        node_drv <= 1'h0;
        count_until(1, 60);
        check_in(t, 19 + lag, 22 + lag);
        repeat (20) @(posedge aclk);
        expect_reg(8'h0c, status_word(3'h0, 1'h1, 4'h0, 1'h0));
        for (int m = 0; m < 4; m++) begin
            sel = m[0];
            stp = m[1];
            pm = pm_expect(stp, sel);
            axi_write(8'h00, {31'h0, sel}, 4'hf);
            expect_reg(8'h08, 32'h0);
            pulse_cpu(stp);
            expect_reg(8'h0c, status_word(pm, pm == 3'h1, 4'h0, 1'h0));
            tx_bit_in <= 1'h1;
            repeat (4) @(posedge aclk);
            check(tx_digital_out, 1'h0);
            tx_bit_in <= 1'h0;
            node_drv <= 1'h1;
            count_until(2, 20);
            check({wake_irq, wake_nmi}, {pm == 3'h1, pm != 3'h1});
            node_drv <= 1'h0;
            count_until(3, 1200);
            check_in(t, (pm == 3'h3) ? jlp_pkg::OSC_SETTLE_CYC - 5 : 1,
                     (pm == 3'h3) ? jlp_pkg::OSC_SETTLE_CYC + 5 : 1);
            expect_reg(8'h08, (pm == 3'h1) ? 32'h0 : {24'h0, jlp_pkg::WAKE_VECTOR});
            expect_reg(8'h08, 32'h0);
            expect_reg(8'h00, {31'h0, sel});
            repeat (30) @(posedge aclk);
            expect_reg(8'h0c, status_word(3'h0, 1'h1, 4'h0, 1'h0));
        end
        tx_bit_in <= 1'h1;
        repeat (30) @(posedge aclk);
        check({tx_digital_out, rx_filtered}, 2'h3);
        axi_write(8'h04, 32'h2, 4'hf);
        repeat (30) @(posedge aclk);
        check({tx_digital_out, rx_filtered, link_enable}, 3'h2);
        tx_bit_in <= 1'h0;
        repeat (30) @(posedge aclk);
        check(rx_filtered, 1'h0);
        axi_write(8'h00, 32'h0, 4'hf);
        pulse_cpu(1'h0);
        node_drv <= 1'h1;
        seen = 1'h0;
        repeat (30) begin
            @(posedge aclk);
            seen = seen | wake_irq | wake_nmi;
        end
        check(seen, 1'h0);
        node_drv <= 1'h0;
        axi_write(8'h04, 32'h0, 4'hf);
        repeat (10) @(posedge aclk);
        node_drv <= 1'h1;
        count_until(2, 20);
        check(wake_irq, 1'h1);
        node_drv <= 1'h0;
        xcvr_loop <= 1'h1;
        axi_write(8'h04, 32'h1, 4'hf);
        repeat (3) @(posedge aclk);
        check(link_enable, 1'h0);
        axi_write(8'h04, 32'h0, 4'hf);
        xcvr_loop <= 1'h0;
        count_until(4, 4000);
        check_in(t, jlp_pkg::IDLE_CYC - 5, jlp_pkg::IDLE_CYC + 5);
        end_of_test();
    end
endmodule
`default_nettype wire
